/* File: otpp_params.svh */
`ifndef OTPP_PARAMS_SVH
`define OTPP_PARAMS_SVH
`define OTPP_MODE_RESERVED 2'h0
`define OTPP_MODE_VERSION 2'h1
`define OTPP_MODE_LOCK 2'h2
`define OTPP_MODE_MEMORY 2'h3
`define OTPP_ERASED_BYTE 8'hff
`define OTPP_LOCK_RESET 2'h3
`define OTPP_LOCK_LSB 0
`define OTPP_HADDR_W 7
`define OTPP_WRITE_STROBE_TIME_NS 100000
`define OTPP_CLK_PERIOD_NS 50
`define OTPP_WRITE_STROBE_CYCLES ((`OTPP_WRITE_STROBE_TIME_NS + `OTPP_CLK_PERIOD_NS - 1) / `OTPP_CLK_PERIOD_NS)
`endif

/* File: otpp_pkg.sv */
package otpp_pkg;
	typedef enum logic [1:0] {
		OTPP_RESERVED = 2'b00,
		OTPP_VERSION = 2'b01,
		OTPP_LOCK = 2'b10,
		OTPP_MEMORY = 2'b11
	} otpp_mode_e;
	typedef enum logic [1:0] {
		OTPP_IDLE = 2'b00,
		OTPP_BURN = 2'b01,
		OTPP_WAIT = 2'b10
	} otpp_state_e;
	typedef struct packed {
		logic [1:0] mode;
		logic [14:0] addr;
		logic [7:0] data;
	} otpp_write_s;
endpackage

/* File: otpp_fifo.sv */
// the write queue module lives beside the port logic in otpp_port.sv

/* File: otpp_port.sv */
`timescale 1ns/10ps
`include "otpp_params.svh"
// Contract
// RULE1: programmer holds reset high throughout
// RULE2: programmer holds store enable low throughout
// RULE3: select pins pick memory, lock, version
// RULE4: latch strobe low while select changes
// RULE5: high address captured on strobe fall
// RULE6: address port carries low, latched high
// RULE7: read strobe controls all reads
// RULE8: write strobe programs bytes and locks
// RULE9: write strobe low during mode entry
// RULE10: programmer follows mode entry sequence
// RULE11: programming voltage present while programming
// RULE12: vpp pin logic high during reads
// RULE13: vpp pin low during mode entry
// RULE14: data port bidirectional, direction per access
// RULE15: device acts as slave memory
// RULE16: version mode returns addressed signature byte
// RULE17: two lock bits, readable, four levels
// RULE18: drive data only during strobed read
module otpp_port #(
	parameter int MEM_DEPTH = 32768,
	parameter int FIFO_DEPTH = 8,
	parameter int WRITE_STROBE_CYCLES = `OTPP_WRITE_STROBE_CYCLES,
	parameter logic [7:0] VERSION_BYTE0 = 8'h5a, // arbitrary value
	parameter logic [7:0] VERSION_BYTE1 = 8'ha5 // arbitrary value
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_reset_pin,
	input wire logic i_store_enable_pin,
	input wire logic i_write_strobe_select,
	input wire logic i_access_mode_select_lo,
	input wire logic i_access_mode_select_hi,
	input wire logic i_high_address_latch_strobe,
	input wire logic i_read_strobe_n,
	input wire logic i_write_strobe_n,
	input wire logic i_external_access_vpp_pin,
	input wire logic [7:0] i_address_port,
	input wire logic [7:0] i_data_port,
	output logic [7:0] o_data_port,
	output logic o_data_port_oe,
	output logic o_busy
);
	// ****************
	// mode and address
	// ****************
	logic write_strobe_mode;
	logic ale_q;
	logic wr_q;
	logic [`OTPP_HADDR_W-1:0] high_addr;
	otpp_pkg::otpp_mode_e mode;
	assign mode = otpp_pkg::otpp_mode_e'({i_access_mode_select_hi, i_access_mode_select_lo}); // [RULE3]
	// slave mode only while reset high and store enable low; entry waveform assumed done
	wire in_write_strobe = i_reset_pin && !i_store_enable_pin && i_write_strobe_select; // [RULE15]
	wire [14:0] full_addr = {high_addr, i_address_port}; // [RULE6]
	wire ale_fall = ale_q && !i_high_address_latch_strobe;
	wire wr_fall = wr_q && !i_write_strobe_n;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ale_q <= 1'b0;
			wr_q <= 1'b1;
			write_strobe_mode <= 1'b0;
			high_addr <= '0;
		end else begin
			ale_q <= i_high_address_latch_strobe;
			wr_q <= i_write_strobe_n;
			write_strobe_mode <= in_write_strobe;
			if (ale_fall) begin
				high_addr <= i_address_port[`OTPP_HADDR_W-1:0]; // [RULE5]
			end
		end
	end
	// ****************
	// write queue
	// ****************
	// writes queue up so a fast programmer is not lost during burn time
	otpp_pkg::otpp_write_s wr_in;
	otpp_pkg::otpp_write_s wr_out;
	logic wq_ready;
	logic wq_valid;
	logic burn_ready;
	assign wr_in = '{mode: mode, addr: full_addr, data: i_data_port};
	wire wr_ok = mode == otpp_pkg::OTPP_MEMORY || mode == otpp_pkg::OTPP_LOCK;
	wire push = write_strobe_mode && wr_fall && wr_ok; // [RULE8]
	otpp_fifo #(
		.WIDTH($bits(otpp_pkg::otpp_write_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_valid(push),
		.o_ready(wq_ready),
		.i_data(wr_in),
		.o_valid(wq_valid),
		.i_ready(burn_ready),
		.o_data(wr_out)
	);
	// ****************
	// burn engine
	// ****************
	logic [7:0] mem [MEM_DEPTH];
	logic [1:0] lock;
	logic [$clog2(WRITE_STROBE_CYCLES+1)-1:0] burn_cnt;
	otpp_pkg::otpp_state_e state;
	otpp_pkg::otpp_write_s cur;
	assign burn_ready = (state == otpp_pkg::OTPP_IDLE);
	// level 1 and above forbid further array programming
	wire array_locked = lock != `OTPP_LOCK_RESET;
	wire burn_done = (state == otpp_pkg::OTPP_BURN) && burn_cnt == '0;
	always_ff @(posedge i_clk) begin
		if (burn_done && cur.mode == otpp_pkg::OTPP_MEMORY && !array_locked) begin
			// otp cells only go from 1 to 0
			mem[cur.addr[$clog2(MEM_DEPTH)-1:0]] <= mem[cur.addr[$clog2(MEM_DEPTH)-1:0]] & cur.data;
		end
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= otpp_pkg::OTPP_IDLE;
			burn_cnt <= '0;
			cur <= '0;
			lock <= `OTPP_LOCK_RESET;
		end else begin
			case (state)
				otpp_pkg::OTPP_IDLE: begin
					if (wq_valid) begin
						cur <= wr_out;
						burn_cnt <= ($clog2(WRITE_STROBE_CYCLES+1))'(WRITE_STROBE_CYCLES - 1);
						state <= otpp_pkg::OTPP_BURN;
					end
				end
				otpp_pkg::OTPP_BURN: begin
					if (burn_cnt != '0) begin
						burn_cnt <= burn_cnt - 1'b1;
					end else begin
						if (cur.mode == otpp_pkg::OTPP_LOCK) begin
							lock <= lock & cur.data[`OTPP_LOCK_LSB+:2]; // [RULE17]
						end
						state <= otpp_pkg::OTPP_WAIT;
					end
				end
				default: begin
					state <= otpp_pkg::OTPP_IDLE;
				end
			endcase
		end
	end
	// ****************
	// read path
	// ****************
	logic [7:0] rd_mem;
	logic [7:0] rd_byte;
	wire read_on = write_strobe_mode && !i_read_strobe_n && mode != otpp_pkg::OTPP_RESERVED; // [RULE7]
	wire [7:0] ver_byte = i_address_port[0] ? VERSION_BYTE1 : VERSION_BYTE0; // [RULE16]
	// level 2 and 3 hide the array from reads
	wire read_blocked = !lock[1];
	assign rd_byte = (mode == otpp_pkg::OTPP_VERSION) ? ver_byte :
		(mode == otpp_pkg::OTPP_LOCK) ? {6'h00, lock} : // [RULE17]
		(read_blocked ? `OTPP_ERASED_BYTE : rd_mem);
	always_ff @(posedge i_clk) begin
		rd_mem <= mem[full_addr[$clog2(MEM_DEPTH)-1:0]];
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_data_port <= 8'h00;
			o_data_port_oe <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			o_data_port <= rd_byte; // [RULE14]
			o_data_port_oe <= read_on; // [RULE18]
			o_busy <= wq_valid || state != otpp_pkg::OTPP_IDLE || !wq_ready;
		end
	end
endmodule

// ****************
// write queue storage
// ****************
module otpp_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	// one spare bit so a full queue differs from an empty one
	logic [AW:0] count;
	wire push = i_valid && o_ready;
	wire pop = o_valid && i_ready;
	assign o_ready = (count != (AW+1)'(DEPTH));
	assign o_valid = (count != '0);
	assign o_data = mem[rd_ptr];
	// storage needs no reset; only the pointers and the count carry state
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_data;
		end
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* File: otpp_port_sva.sv */
`timescale 1ns/10ps
// ***********
// port checks
// ***********
module otpp_port_sva #(
	parameter int WRITE_STROBE_CYCLES = 4
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_access_mode_select_lo,
	input wire logic i_access_mode_select_hi,
	input wire logic i_read_strobe_n,
	input wire logic i_write_strobe_n,
	input wire logic [7:0] i_address_port,
	input wire logic [7:0] o_data_port,
	input wire logic o_data_port_oe,
	input wire logic o_busy
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	wire logic [1:0] mode = {i_access_mode_select_hi, i_access_mode_select_lo};
	logic [15:0] busy_len;
	// one full queue of eight burns plus slack; longer means a burn never ends
	always_ff @(posedge i_clk or negedge i_resetn)
		if (!i_resetn) busy_len <= '0;
		else busy_len <= o_busy ? busy_len + 16'h1 : '0;
	a_oe_has_cause: assert property (o_data_port_oe |-> $past(!i_read_strobe_n && mode != 2'h0))
		else $error("data driven without read");
	a_oe_release: assert property (!i_read_strobe_n ##1 i_read_strobe_n |=> !o_data_port_oe)
		else $error("data still driven after read");
	a_idle_quiet: assert property (i_read_strobe_n && $past(i_read_strobe_n) |-> !o_data_port_oe)
		else $error("data driven while idle");
	a_read_answer: assert property ((!i_read_strobe_n && mode != 2'h0) [*3] |=> o_data_port_oe)
		else $error("read not answered");
	a_version_byte: assert property ((!i_read_strobe_n && mode == 2'h1 && $stable(i_address_port)) [*3]
		|=> o_data_port == ($past(i_address_port[0]) ? 8'ha5 : 8'h5a))
		else $error("wrong version byte");
	a_write_queued: assert property ($fell(i_write_strobe_n) && mode == 2'h2 && !o_busy |-> ##[1:3] o_busy)
		else $error("lock write not taken");
	a_read_mode_nowrite: assert property ($fell(i_write_strobe_n) && !mode[1] && !o_busy |=> !o_busy [*4])
		else $error("write taken in read-only mode");
	a_burn_bounded: assert property (busy_len < 8 * (WRITE_STROBE_CYCLES + 2) + 16)
		else $error("busy too long");
	c_version: cover property (mode == 2'h1 && o_data_port_oe);
	c_memory: cover property (mode == 2'h3 && o_data_port_oe);
	c_burn_done: cover property ($fell(o_busy));
endmodule

/* File: otpp_write_strobe_model.sv */
`timescale 1ns/10ps
// **************
// programmer side
// **************
module otpp_write_strobe_model (
	input wire logic i_clk,
	input wire logic i_drive,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] i_dev_data,
	input wire logic i_dev_oe,
	output logic [7:0] o_bus
);
	logic [7:0] last = 8'h00;
	always_ff @(posedge i_clk) last <= o_bus;
	// floating bus shows the inverse of the previous cycle, so stale data comes back every other cycle
	assign o_bus = i_dev_oe ? i_dev_data : i_drive ? i_wdata : ~last;
endmodule

/* File: test_otp_programming_port.sv */
`timescale 1ns/10ps
bind otpp_port otpp_port_sva #(.WRITE_STROBE_CYCLES(WRITE_STROBE_CYCLES)) u_sva(.i_clk, .i_resetn,
	.i_access_mode_select_lo, .i_access_mode_select_hi, .i_read_strobe_n, .i_write_strobe_n,
	.i_address_port, .o_data_port, .o_data_port_oe, .o_busy);
module test_otp_programming_port;
	logic i_clk = 0, i_resetn = 0, lo = 0, hi = 0, ale = 0, rd_n = 1, wr_n = 1, drive = 0;
	logic [7:0] addr = 0, wdata = 0, bus, dq, v;
	logic oe, busy;
	int failures = 0, n_checks = 0, cyc = 0;
	always #25 i_clk = ~i_clk;
	// reset, store enable, select and supply pins held static after entry
	otpp_port #(.WRITE_STROBE_CYCLES(4)) u_dut(.i_clk, .i_resetn, .i_reset_pin(1'b1),
		.i_store_enable_pin(1'b0), .i_write_strobe_select(1'b1), .i_access_mode_select_lo(lo),
		.i_access_mode_select_hi(hi), .i_high_address_latch_strobe(ale), .i_read_strobe_n(rd_n),
		.i_write_strobe_n(wr_n), .i_external_access_vpp_pin(1'b1), .i_address_port(addr),
		.i_data_port(bus), .o_data_port(dq), .o_data_port_oe(oe), .o_busy(busy));
	otpp_write_strobe_model u_write_strobe(.i_clk, .i_drive(drive), .i_wdata(wdata), .i_dev_data(dq),
		.i_dev_oe(oe), .o_bus(bus));
	task tick; @(posedge i_clk); #2; endtask
	task chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task sel(input logic [1:0] m); ale = 0; {hi, lo} = m; tick; endtask
	task latch(input logic [7:0] h); addr = h; ale = 1; tick; ale = 0; tick; endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		int k;
		addr = a; wdata = d; drive = 1; wr_n = 0; tick; tick; wr_n = 1; drive = 0; tick;
		k = 0;
		while (busy === 1'b1 && k < 100) begin
			tick;
			k++;
		end
		chk("busy", {7'h0, busy}, 8'h0);
	endtask
	task rd(input logic [7:0] a, input logic eoe);
		addr = a; tick; rd_n = 0; tick; tick; tick; v = bus;
		chk("oe", {7'h0, oe}, {7'h0, eoe});
		rd_n = 1; tick; tick;
		chk("release", {7'h0, oe}, 8'h0);
	endtask
	task t_version;
		sel(2'h1);
		rd(8'h00, 1); chk("ver0", v, 8'h5a);
		rd(8'h01, 1); chk("ver1", v, 8'ha5);
		wr(8'h00, 8'h00);
		sel(2'h0); rd(8'h00, 0);
		$display("version and reserved done");
	endtask
	task t_memory;
		sel(2'h3); latch(8'h12);
		wr(8'h34, 8'h00); rd(8'h34, 1); chk("mem", v, 8'h00);
		sel(2'h2); rd(8'h00, 1); chk("lock0", {6'h0, v[1:0]}, 8'h03);
		$display("memory done");
	endtask
	task t_lock;
		sel(2'h2); wr(8'h00, 8'h01); rd(8'h00, 1); chk("lock1", {6'h0, v[1:0]}, 8'h01);
		sel(2'h3); rd(8'h34, 1); chk("guard", v, 8'hff);
		$display("lock done");
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			report_and_stop;
		end
	end
	initial begin
		repeat (5) @(posedge i_clk);
		#2 i_resetn = 1;
		tick; tick;
		t_version; t_memory; t_lock;
		report_and_stop;
	end
endmodule
